// ### ccr_pkg.sv
// Purpose: Shared constants and types for the charger control register pair.
// Assumes: Two-wire serial register access; 8-bit registers.
// Notes: Field positions refer to bit numbers inside each register byte.

package ccr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [6:0] CCR_SLAVE_ADDR_DEFAULT = 7'h6b;
	localparam logic [7:0] CCR_CHARGE_BOOST_CONFIG_ADDR = 8'h03;
	localparam logic [7:0] CCR_CHARGE_CURRENT_CONFIG_ADDR = 8'h04;
	localparam logic [7:0] CCR_UNMAPPED_READ = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CCR_CB_STATUS_BIT = 7;
	localparam int CCR_CB_WD_RESTART_BIT = 6;
	localparam int CCR_CB_BOOST_BIT = 5;
	localparam int CCR_CB_CHARGE_BIT = 4;
	localparam int CCR_CB_MIN_VOLT_MSB = 3;
	localparam int CCR_CB_MIN_VOLT_LSB = 1;
	localparam int CCR_CB_LOW_BAT_BIT = 0;
	localparam int CCR_CC_PULSE_BIT = 7;
	localparam int CCR_CC_CODE_MSB = 6;
	localparam int CCR_CC_CODE_LSB = 0;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [7:0] CCR_CHARGE_BOOST_RESET = 8'h1a;
	localparam logic [7:0] CCR_CHARGE_CURRENT_RESET = 8'h20;
	localparam logic [6:0] CCR_CURRENT_CODE_OFF = 7'h00;
	localparam logic [6:0] CCR_CURRENT_CODE_MAX = 7'h3f;
	localparam logic [3:0] CCR_BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CCR_IDLE = 3'h0,
		CCR_ADDR = 3'h1,
		CCR_ACK = 3'h2,
		CCR_RECV = 3'h3,
		CCR_SEND = 3'h4,
		CCR_MACK = 3'h5
	} ccr_bus_state_t;

	typedef struct packed {
		logic adapter_present;
		logic boost_mode;
		logic port_detection_active;
		logic dedicated_adapter;
	} ccr_source_t;

	typedef struct packed {
		logic charge_enable;
		logic boost_output_enable;
		logic [2:0] min_system_voltage_code;
		logic low_battery_threshold_select;
		logic pulse_current_control_enable;
		logic [6:0] fast_charge_current_code;
	} ccr_config_t;

endpackage

// ### ccr_sync.sv
// Purpose: Two-stage synchroniser for levels entering the mclk domain.
// Assumes: Inputs are levels; each bit is synchronised on its own.
// Notes: Also serves as the reset release synchroniser.

`timescale 1ns/1ns

module ccr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} ccr_sync_state_t;

	ccr_sync_state_t cur;
	ccr_sync_state_t next_cur;

	// The first stage feeds only the second stage.
	always_comb begin
		next_cur = cur;
		next_cur.meta = async_in;
		next_cur.stable = cur.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur.meta <= RESET_VALUE;
			cur.stable <= RESET_VALUE;
		end else begin
			cur <= next_cur;
		end
	end

	assign sync_out = cur.stable;

endmodule

// ### ccr_pin_steer.sv
// Purpose: Decides the level of the status and detect-select pins.
// Assumes: Adapter present and boost mode are never both true.
// Notes: Purely combinational; the caller registers the results.

`timescale 1ns/1ns

module ccr_pin_steer #(
	parameter bit HAS_DETECT_SELECT = 1'b0
) (
	// Power source state
	input ccr_pkg::ccr_source_t source,
	input wire logic select_bit,
	// Pin levels
	output logic input_good_status,
	output logic detect_select
);

	import ccr_pkg::*;

	logic status_level;
	logic select_level;

	always_comb begin
		status_level = 1'b0;
		if (source.adapter_present) begin
			status_level = 1'b1; // see R1
		end else if (source.boost_mode) begin
			status_level = select_bit; // see R1
		end
	end

	always_comb begin
		select_level = 1'b0; // see R5
		if (source.adapter_present) begin
			if (source.port_detection_active || source.dedicated_adapter) begin
				select_level = 1'b1; // see R2
			end else begin
				select_level = select_bit; // see R3
			end
		end else if (source.boost_mode) begin
			select_level = select_bit; // see R4
		end
	end

	// The variant strap picks which pin owns the select bit.
	assign input_good_status = HAS_DETECT_SELECT ? 1'b0 : status_level;
	assign detect_select = HAS_DETECT_SELECT ? select_level : 1'b0;

endmodule

// ### ccr_top.sv
// Purpose: Charge/boost and charge-current configuration registers behind
//          a two-wire serial slave, with status and detect-select pins.
// Assumes: Source state, register reset and watchdog expiry come from
//          logic on mclk; the serial pins come from outside.
// Notes: The serial clock is sampled by mclk, so it must stay well below
//        a quarter of mclk. No clock stretching is done.

`timescale 1ns/1ns

// Operation
// R1 - Status pin: adapter high, boost follows, battery low
// R2 - Detect-select high during detection or dedicated adapter
// R3 - Other source: detect-select equals force bit
// R4 - Boost mode: detect-select follows force bit
// R5 - Battery only: detect-select low; bit7 software reset (here bit7 is the status/detect-select force bit, no reset)
// R6 - Restart bit pulses watchdog restart, self-clears
// R7 - Boost and charge enables reset on both resets
// R8 - Minimum system voltage code, register reset only
// R9 - Low battery threshold select, register reset only
// R10 - Pulse current control enable, both resets
// R11 - Fast charge current code, both resets
// R12 - Zero current code disables charging
// R13 - Current code above maximum is clamped
// R14 - Watchdog expiry restores defaults of these fields
// R15 - Reads return held values; restart reads zero
module ccr_top #(
	parameter logic [6:0] SLAVE_ADDR = ccr_pkg::CCR_SLAVE_ADDR_DEFAULT,
	parameter bit HAS_DETECT_SELECT = 1'b0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Two-wire serial register interface
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Charger state from the rest of the device
	input ccr_pkg::ccr_source_t source,
	input wire logic register_reset,
	input wire logic watchdog_expired,
	// Configuration towards the charger
	output logic watchdog_restart,
	output ccr_pkg::ccr_config_t config_out,
	// Pins
	output logic input_good_status_out,
	output logic detect_select_out
);

	import ccr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ccr_bus_state_t state;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic ptr_loaded;
		logic rw;
		logic master_ack;
		logic sda_oe;
		logic scl_q;
		logic sda_q;
		logic status_select;
		logic wd_restart;
		logic boost_en;
		logic charge_en;
		logic [2:0] min_volt;
		logic low_bat_sel;
		logic pulse_en;
		logic [6:0] current_code;
		logic status_pin;
		logic detect_pin;
		ccr_config_t cfg;
	} ccr_top_state_t;

	ccr_top_state_t cur;
	ccr_top_state_t next_cur;

	logic rst_sync_n;
	logic [1:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] read_data;
	logic steer_status;
	logic steer_select;
	logic [6:0] clamped_code;

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	ccr_sync #(
		.WIDTH(1),
		.RESET_VALUE(1'b0)
	) u_reset_sync (
		.clk(mclk),
		.rst_n(rst_n),
		.async_in(1'b1),
		.sync_out(rst_sync_n)
	);

	// The bus idles high, so the synchroniser starts high to avoid a
	// false edge right after reset.
	ccr_sync #(
		.WIDTH(2),
		.RESET_VALUE(2'b11)
	) u_pin_sync (
		.clk(mclk),
		.rst_n(rst_sync_n),
		.async_in({scl_in, sda_in}),
		.sync_out(pins_sync)
	);

	assign scl_s = pins_sync[1];
	assign sda_s = pins_sync[0];
	assign scl_rise = scl_s & ~cur.scl_q;
	assign scl_fall = ~scl_s & cur.scl_q;
	assign bus_start = scl_s & cur.scl_q & cur.sda_q & ~sda_s;
	assign bus_stop = scl_s & cur.scl_q & ~cur.sda_q & sda_s;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_byte(input ccr_top_state_t s);
		logic [7:0] b;
		b = CCR_UNMAPPED_READ;
		if (s.ptr == CCR_CHARGE_BOOST_CONFIG_ADDR) begin
			b[CCR_CB_STATUS_BIT] = s.status_select; // see R15
			b[CCR_CB_WD_RESTART_BIT] = s.wd_restart; // see R15
			b[CCR_CB_BOOST_BIT] = s.boost_en;
			b[CCR_CB_CHARGE_BIT] = s.charge_en;
			b[CCR_CB_MIN_VOLT_MSB:CCR_CB_MIN_VOLT_LSB] = s.min_volt;
			b[CCR_CB_LOW_BAT_BIT] = s.low_bat_sel;
		end else if (s.ptr == CCR_CHARGE_CURRENT_CONFIG_ADDR) begin
			b[CCR_CC_PULSE_BIT] = s.pulse_en; // see R15
			b[CCR_CC_CODE_MSB:CCR_CC_CODE_LSB] = s.current_code;
		end
		return b;
	endfunction

	assign read_data = read_byte(cur);

	// ----------------------------------------------------------------
	// Pin steering
	// ----------------------------------------------------------------
	ccr_pin_steer #(
		.HAS_DETECT_SELECT(HAS_DETECT_SELECT)
	) u_pin_steer (
		.source(source),
		.select_bit(cur.status_select),
		.input_good_status(steer_status),
		.detect_select(steer_select)
	);

	// Codes above the top step are held at the top step.
	assign clamped_code = (cur.current_code > CCR_CURRENT_CODE_MAX) ?
		CCR_CURRENT_CODE_MAX : cur.current_code; // see R13

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		wr_en = 1'b0;
		wr_addr = cur.ptr;
		wr_data = cur.shift;
		next_cur.scl_q = scl_s;
		next_cur.sda_q = sda_s;
		next_cur.wd_restart = 1'b0; // see R6

		// Serial slave. A start or stop is honoured in any state.
		if (bus_start) begin
			next_cur.state = CCR_ADDR;
			next_cur.bit_cnt = 4'h0;
			next_cur.ptr_loaded = 1'b0;
			next_cur.sda_oe = 1'b0;
		end else if (bus_stop) begin
			next_cur.state = CCR_IDLE;
			next_cur.sda_oe = 1'b0;
		end else begin
			case (cur.state)
				CCR_IDLE: begin
					next_cur.sda_oe = 1'b0;
				end
				CCR_ADDR: begin
					if (scl_rise) begin
						next_cur.shift = {cur.shift[6:0], sda_s};
						next_cur.bit_cnt = cur.bit_cnt + 4'h1;
					end else if (scl_fall && cur.bit_cnt == CCR_BITS_PER_BYTE) begin
						if (cur.shift[7:1] == SLAVE_ADDR) begin
							next_cur.rw = cur.shift[0];
							next_cur.sda_oe = 1'b1;
							next_cur.state = CCR_ACK;
						end else begin
							next_cur.state = CCR_IDLE;
						end
					end
				end
				CCR_ACK: begin
					if (scl_fall) begin
						if (cur.rw) begin
							next_cur.shift = read_data;
							next_cur.sda_oe = ~read_data[7];
							next_cur.bit_cnt = 4'h1;
							next_cur.state = CCR_SEND;
						end else begin
							next_cur.sda_oe = 1'b0;
							next_cur.bit_cnt = 4'h0;
							next_cur.state = CCR_RECV;
						end
					end
				end
				CCR_RECV: begin
					if (scl_rise) begin
						next_cur.shift = {cur.shift[6:0], sda_s};
						next_cur.bit_cnt = cur.bit_cnt + 4'h1;
					end else if (scl_fall && cur.bit_cnt == CCR_BITS_PER_BYTE) begin
						next_cur.sda_oe = 1'b1;
						next_cur.state = CCR_ACK;
						if (cur.ptr_loaded) begin
							wr_en = 1'b1;
							next_cur.ptr = cur.ptr + 8'h01;
						end else begin
							next_cur.ptr = cur.shift;
							next_cur.ptr_loaded = 1'b1;
						end
					end
				end
				CCR_SEND: begin
					if (scl_fall) begin
						if (cur.bit_cnt == CCR_BITS_PER_BYTE) begin
							next_cur.sda_oe = 1'b0;
							next_cur.ptr = cur.ptr + 8'h01;
							next_cur.state = CCR_MACK;
						end else begin
							next_cur.sda_oe = ~cur.shift[6];
							next_cur.shift = {cur.shift[6:0], 1'b0};
							next_cur.bit_cnt = cur.bit_cnt + 4'h1;
						end
					end
				end
				CCR_MACK: begin
					if (scl_rise) begin
						next_cur.master_ack = ~sda_s;
					end else if (scl_fall) begin
						if (cur.master_ack) begin
							next_cur.shift = read_data;
							next_cur.sda_oe = ~read_data[7];
							next_cur.bit_cnt = 4'h1;
							next_cur.state = CCR_SEND;
						end else begin
							next_cur.state = CCR_IDLE;
						end
					end
				end
				default: begin
					next_cur.state = CCR_IDLE;
					next_cur.sda_oe = 1'b0;
				end
			endcase
		end

		// Register writes.
		if (wr_en && wr_addr == CCR_CHARGE_BOOST_CONFIG_ADDR) begin
			next_cur.status_select = wr_data[CCR_CB_STATUS_BIT]; // see R5
			next_cur.wd_restart = wr_data[CCR_CB_WD_RESTART_BIT]; // see R6
			next_cur.boost_en = wr_data[CCR_CB_BOOST_BIT]; // see R7
			next_cur.charge_en = wr_data[CCR_CB_CHARGE_BIT]; // see R7
			next_cur.min_volt =
				wr_data[CCR_CB_MIN_VOLT_MSB:CCR_CB_MIN_VOLT_LSB]; // see R8
			next_cur.low_bat_sel = wr_data[CCR_CB_LOW_BAT_BIT]; // see R9
		end
		if (wr_en && wr_addr == CCR_CHARGE_CURRENT_CONFIG_ADDR) begin
			next_cur.pulse_en = wr_data[CCR_CC_PULSE_BIT]; // see R10
			next_cur.current_code =
				wr_data[CCR_CC_CODE_MSB:CCR_CC_CODE_LSB]; // see R11
		end

		// Defaults win over a host write in the same cycle, so the
		// charger never runs with an enable, pulse or current code written just as it expired.
		if (watchdog_expired) begin
			next_cur.wd_restart = 1'b0; // see R14
			next_cur.boost_en = CCR_CHARGE_BOOST_RESET[CCR_CB_BOOST_BIT]; // see R7
			next_cur.charge_en =
				CCR_CHARGE_BOOST_RESET[CCR_CB_CHARGE_BIT]; // see R7
			next_cur.pulse_en =
				CCR_CHARGE_CURRENT_RESET[CCR_CC_PULSE_BIT]; // see R10
			next_cur.current_code =
				CCR_CHARGE_CURRENT_RESET[CCR_CC_CODE_MSB:CCR_CC_CODE_LSB]; // see R11
		end
		if (register_reset) begin
			next_cur.boost_en = CCR_CHARGE_BOOST_RESET[CCR_CB_BOOST_BIT]; // see R7
			next_cur.charge_en =
				CCR_CHARGE_BOOST_RESET[CCR_CB_CHARGE_BIT]; // see R7
			next_cur.min_volt = CCR_CHARGE_BOOST_RESET[
				CCR_CB_MIN_VOLT_MSB:CCR_CB_MIN_VOLT_LSB]; // see R8
			next_cur.low_bat_sel =
				CCR_CHARGE_BOOST_RESET[CCR_CB_LOW_BAT_BIT]; // see R9
			next_cur.pulse_en =
				CCR_CHARGE_CURRENT_RESET[CCR_CC_PULSE_BIT]; // see R10
			next_cur.current_code =
				CCR_CHARGE_CURRENT_RESET[CCR_CC_CODE_MSB:CCR_CC_CODE_LSB]; // see R11
		end

		// Registered outputs, one cycle behind the held fields.
		next_cur.status_pin = steer_status;
		next_cur.detect_pin = steer_select;
		next_cur.cfg.charge_enable = cur.charge_en &&
			(cur.current_code != CCR_CURRENT_CODE_OFF); // see R12
		next_cur.cfg.boost_output_enable = cur.boost_en;
		next_cur.cfg.min_system_voltage_code = cur.min_volt;
		next_cur.cfg.low_battery_threshold_select = cur.low_bat_sel;
		next_cur.cfg.pulse_current_control_enable = cur.pulse_en;
		next_cur.cfg.fast_charge_current_code = clamped_code; // see R13
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur <= '0;
			cur.state <= CCR_IDLE;
			cur.scl_q <= 1'b1;
			cur.sda_q <= 1'b1;
			cur.status_select <= CCR_CHARGE_BOOST_RESET[CCR_CB_STATUS_BIT];
			cur.boost_en <= CCR_CHARGE_BOOST_RESET[CCR_CB_BOOST_BIT];
			cur.charge_en <= CCR_CHARGE_BOOST_RESET[CCR_CB_CHARGE_BIT];
			cur.min_volt <=
				CCR_CHARGE_BOOST_RESET[CCR_CB_MIN_VOLT_MSB:CCR_CB_MIN_VOLT_LSB];
			cur.low_bat_sel <= CCR_CHARGE_BOOST_RESET[CCR_CB_LOW_BAT_BIT];
			cur.pulse_en <= CCR_CHARGE_CURRENT_RESET[CCR_CC_PULSE_BIT];
			cur.current_code <=
				CCR_CHARGE_CURRENT_RESET[CCR_CC_CODE_MSB:CCR_CC_CODE_LSB];
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open drain: the pad only ever pulls low.
	assign sda_out = 1'b0;
	assign sda_oe = cur.sda_oe;
	assign watchdog_restart = cur.wd_restart;
	assign config_out = cur.cfg;
	assign input_good_status_out = cur.status_pin;
	assign detect_select_out = cur.detect_pin;

endmodule

// ### ccr_monitor.sv
// Purpose: Port-level checks of the charger control register pair.
// Assumes: Single mclk domain; serial link sampled by mclk.
// Notes: Checks qualified by ok start seven edges after reset release; the restart, zero-code and clamp checks run from release.

`timescale 1ns/1ns

module ccr_monitor #(
	parameter bit HAS_DETECT_SELECT = 1'b0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Observed ports
	input wire logic scl_in,
	input wire logic sda_oe,
	input ccr_pkg::ccr_source_t source,
	input wire logic register_reset,
	input wire logic watchdog_expired,
	input wire logic watchdog_restart,
	input ccr_pkg::ccr_config_t config_out,
	input wire logic input_good_status_out,
	input wire logic detect_select_out
);
	import ccr_pkg::*;
	logic [2:0] age;
	logic ok;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// Settling guard
	// ----------------------------------------------------------------
	// The reset synchroniser delays the fields, so early edges are skipped.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			age <= 3'h0;
		else if (!ok)
			age <= age + 3'h1;
	end
	assign ok = &age;

	status_high_a: assert property (
		(ok && !HAS_DETECT_SELECT && source.adapter_present) [*3]
		|-> input_good_status_out)
		else $error("status pin low with adapter present");
	status_low_a: assert property (
		(ok && !source.adapter_present && !source.boost_mode) [*3]
		|-> !input_good_status_out)
		else $error("status pin high on battery only");
	select_high_a: assert property (
		(ok && HAS_DETECT_SELECT && source.adapter_present
		&& (source.port_detection_active || source.dedicated_adapter)) [*3]
		|-> detect_select_out)
		else $error("detect-select low during detection");
	select_low_a: assert property (
		(ok && HAS_DETECT_SELECT && !source.adapter_present
		&& !source.boost_mode) [*3] |-> !detect_select_out)
		else $error("detect-select high on battery only");
	restart_pulse_a: assert property (
		watchdog_restart |=> !watchdog_restart)
		else $error("restart pulse longer than one cycle");
	zero_off_a: assert property (
		config_out.fast_charge_current_code == 7'h00
		|-> !config_out.charge_enable)
		else $error("charging enabled with zero current code");
	clamp_max_a: assert property (
		!config_out.fast_charge_current_code[6])
		else $error("current code above clamp");
	reg_reset_a: assert property (
		ok && register_reset |-> ##2 config_out == 14'h2a20)
		else $error("register reset left wrong fields");
	wd_expire_a: assert property (
		ok && watchdog_expired |-> ##2 (config_out.charge_enable
		&& !config_out.boost_output_enable
		&& !config_out.pulse_current_control_enable
		&& config_out.fast_charge_current_code == 7'h20
		&& config_out.min_system_voltage_code
		== $past(config_out.min_system_voltage_code, 2)))
		else $error("watchdog expiry left wrong fields");
	sda_timing_a: assert property (
		ok && $changed(sda_oe) |-> !scl_in)
		else $error("data line changed while serial clock high");
	floor_cause_a: assert property (
		ok && $changed(config_out.min_system_voltage_code)
		|-> !scl_in || $past(register_reset, 2))
		else $error("system voltage code changed without cause");

	cover property (watchdog_restart);
	cover property (ok && watchdog_expired);
	cover property (ok && register_reset);
	cover property (source.boost_mode && input_good_status_out);
endmodule

bind ccr_top ccr_monitor #(.HAS_DETECT_SELECT(HAS_DETECT_SELECT))
	ccr_monitor_i (.mclk(mclk), .rst_n(rst_n),
	.scl_in(scl_in), .sda_oe(sda_oe), .source(source),
	.register_reset(register_reset), .watchdog_expired(watchdog_expired),
	.watchdog_restart(watchdog_restart), .config_out(config_out),
	.input_good_status_out(input_good_status_out),
	.detect_select_out(detect_select_out));

// ### ccr_host.sv
// Purpose: Behavioural two-wire host that reads and writes registers.
// Assumes: Open-drain data line with a pull-up; 125 ns serial clock.
// Notes: The serial clock stands high between frames.

`timescale 1ns/1ns

module ccr_host (
	// Wire levels
	output logic scl,
	output wire logic sda,
	input wire logic sda_oe
);
	logic sda_m = 1'b1;
	initial scl = 1'b1;
	// Pull-up wins unless someone pulls low.
	assign sda = sda_m & ~sda_oe;

	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	// Data moves 48 ns into the low phase, clear of the mclk edges.
	task automatic start;
		#16 sda_m = 1'b1;
		#15 scl = 1'b1;
		#31 sda_m = 1'b0;
		#31 scl = 1'b0;
		#32;
	endtask
	task automatic stop;
		#16 sda_m = 1'b0;
		#15 scl = 1'b1;
		#31 sda_m = 1'b1;
		#63;
	endtask
	// Eight data bits then the acknowledge bit, MSB first.
	task automatic bit9(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			#16 sda_m = d[i];
			#15 scl = 1'b1;
			#31 q[i] = sda;
			#31 scl = 1'b0;
			#32;
		end
	endtask
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, d,
		output bit ok);
		logic [8:0] q;
		start();
		bit9({a, 2'b01}, q);
		ok = !q[0];
		bit9({p, 1'b1}, q);
		ok = ok & !q[0];
		bit9({d, 1'b1}, q);
		ok = ok & !q[0];
		stop();
	endtask
	task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
		output bit ok);
		logic [8:0] q;
		start();
		bit9({ccr_pkg::CCR_SLAVE_ADDR_DEFAULT, 2'b01}, q);
		ok = !q[0];
		bit9({p, 1'b1}, q);
		ok = ok & !q[0];
		start();
		bit9({ccr_pkg::CCR_SLAVE_ADDR_DEFAULT, 2'b11}, q);
		ok = ok & !q[0];
		bit9(9'h1ff, q);
		d = q[8:1];
		stop();
	endtask
endmodule

// ### test_charger_control_register_pair.sv
// Purpose: Self-checking bench for the charger control register pair.
// Assumes: Both variants share the bus at the default slave address.
// Notes: A shadow copy of both registers gives every config expectation and each mapped read-back; unmapped reads expect zero.

`timescale 1ns/1ns

module test_charger_control_register_pair;
	import ccr_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	ccr_source_t src = '0;
	logic rr = 1'b0;
	logic we = 1'b0;
	wire scl, sda, sda_oe, wdr, igs, oe_d, dso;
	logic ds_exp;
	ccr_config_t cfg;
	int mismatches = 0;
	int num_checks = 0;
	int pulses = 0;
	int p0;
	logic [7:0] r3 = 8'h1a;
	logic [7:0] r4 = 8'h20;
	logic [7:0] q;
	logic [7:0] corner [5] = '{8'h00, 8'h3f, 8'h40, 8'hff, 8'h9f};
	bit ok;

	always #5 mclk = ~mclk;
	always @(posedge mclk) if (wdr === 1'b1) pulses <= pulses + 1;

	ccr_host ccr_host_i (.scl(scl), .sda(sda), .sda_oe(sda_oe | oe_d));
	ccr_top ccr_top_i (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe), .source(src),
		.register_reset(rr), .watchdog_expired(we),
		.watchdog_restart(wdr), .config_out(cfg),
		.input_good_status_out(igs), .detect_select_out());
	// The detect-select variant holds the same registers bit for bit, so
	// both copies pull the data line low together.
	ccr_top #(.HAS_DETECT_SELECT(1'b1)) ccr_top_ds_i (.mclk(mclk),
		.rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(oe_d), .source(src), .register_reset(rr),
		.watchdog_expired(we), .watchdog_restart(), .config_out(),
		.input_good_status_out(), .detect_select_out(dso));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Clamped code is what the charger sees; zero code stops charging.
	function automatic ccr_config_t exp_cfg(input logic [7:0] a, b);
		ccr_config_t c;
		c.charge_enable = a[4] && (b[6:0] != 7'h00);
		c.boost_output_enable = a[5];
		c.min_system_voltage_code = a[3:1];
		c.low_battery_threshold_select = a[0];
		c.pulse_current_control_enable = b[7];
		c.fast_charge_current_code = b[6] ? 7'h3f : b[6:0];
		return c;
	endfunction
	task automatic rd_chk(input logic [7:0] p);
		ccr_host_i.read_reg(p, q, ok);
		chk(ok, 1'b1);
		chk(q, p == 8'h03 ? r3 : p == 8'h04 ? r4 : 8'h00);
		chk(cfg, exp_cfg(r3, r4));
	endtask
	task automatic wr_chk(input logic [7:0] p, d);
		ccr_host_i.write_reg(CCR_SLAVE_ADDR_DEFAULT, p, d, ok);
		chk(ok, 1'b1);
		if (p == 8'h03) r3 = d & 8'hbf;
		if (p == 8'h04) r4 = d;
		rd_chk(p);
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk) s = 1'b1;
		@(negedge mclk) s = 1'b0;
		repeat (4) @(negedge mclk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(11));
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		repeat (10) @(negedge mclk);
		rd_chk(8'h03);
		rd_chk(8'h04);
		foreach (corner[i]) wr_chk(8'h04, corner[i]);
		repeat (6) begin
			wr_chk(8'h03, 8'($urandom) & 8'hbf);
			wr_chk(8'h04, 8'($urandom));
		end
		p0 = pulses;
		wr_chk(8'h03, r3 | 8'h40);
		chk(16'(pulses - p0), 16'h1);
		wr_chk(8'h03, 8'ha7);
		wr_chk(8'h04, 8'h85);
		pulse(we);
		r3 = (r3 & 8'h8f) | 8'h10;
		r4 = 8'h20;
		rd_chk(8'h03);
		wr_chk(8'h04, 8'h85);
		pulse(rr);
		r3 = (r3 & 8'h80) | 8'h1a;
		r4 = 8'h20;
		rd_chk(8'h04);
		rd_chk(8'h03);
		for (int i = 0; i < 6; i++) begin
			wr_chk(8'h03, {i >= 3, 7'h1a});
			@(negedge mclk);
			src.adapter_present = (i % 3) == 1;
			src.boost_mode = (i % 3) == 2;
			src.port_detection_active = 1'($urandom);
			src.dedicated_adapter = 1'($urandom);
			repeat (4) @(negedge mclk);
			chk(igs, (i % 3) == 1 || ((i % 3) == 2 && i >= 3));
			ds_exp = (i % 3) == 2 && i >= 3;
			if ((i % 3) == 1)
				ds_exp = src.port_detection_active ||
					src.dedicated_adapter || i >= 3;
			chk(dso, ds_exp);
		end
		ccr_host_i.write_reg(7'h6a, 8'h03, 8'h00, ok);
		chk(ok, 1'b0);
		rd_chk(8'h03);
		wr_chk(8'h05, 8'h55);
		close_out();
	end

	initial begin
		#600000;
		mismatches++;
		close_out();
	end
endmodule
